// *** rtl/exc_defs.vh ***
`ifndef EXC_DEFS_VH
`define EXC_DEFS_VH

`define EXC_NUM_W        6
`define EXC_NUM_RESET    6'h01
`define EXC_NUM_NMI      6'h02
`define EXC_NUM_HARD     6'h03
`define EXC_NUM_SUP      6'h0B
`define EXC_NUM_PENDREQ  6'h0E
`define EXC_NUM_TICK     6'h0F
`define EXC_NUM_IRQ0     6'h10
`define EXC_NUM_NONE     6'h00

`define VEC_BASE         32'h0000_0000
`define VEC_RESET        32'h0000_0004
`define VEC_NMI          32'h0000_0008
`define VEC_HARD         32'h0000_000C
`define VEC_SUP          32'h0000_002C
`define VEC_IRQ0         32'h0000_0040

`define PRI_W            3
`define PRI_RESET        3'h0
`define PRI_NMI          3'h1
`define PRI_HARD         3'h2
`define PRI_CFG_OFS      3'h3
`define PRI_IDLE         3'h7
`define PRI_CFG_RESET    2'h0

`define NUM_SRC          48
`define NUM_IRQ          32

`endif

// *** rtl/irq_sync.v ***
`timescale 1ns/1ps
module irq_sync (
  input  wire        clk,
  input  wire        rst,
  input  wire [31:0] irq_async,
  output reg  [31:0] irq_rise
);
  reg [31:0] meta_r;
  reg [31:0] sync_r;
  reg [31:0] last_r;

  // RULE19 two flop sync
  always @(posedge clk) begin
    if (rst) begin
      meta_r   <= 32'h0000_0000;
      sync_r   <= 32'h0000_0000;
      last_r   <= 32'h0000_0000;
      irq_rise <= 32'h0000_0000;
    end else begin
      meta_r   <= irq_async;
      sync_r   <= meta_r;
      last_r   <= sync_r;
      // One pulse per rising level, never counted twice
      irq_rise <= sync_r & ~last_r;
    end
  end
endmodule // irq_sync

// *** rtl/exc_state.v ***
// Summary of operation
// RULE1 - Each source is inactive, pending, active, or active and pending.
// RULE2 - Peripheral or software request makes an interrupt pending.
// RULE3 - Higher priority handler may nest; both stay active.
// RULE4 - New request while active makes source active and pending.
// RULE5 - Non-maskable slot exists but never becomes pending.
// RULE6 - Reset stops the core at once, abandoning the instruction.
// RULE7 - Reset has priority -3; restart in thread mode at reset vector.
// RULE8 - Non-maskable has fixed priority -2, unmaskable, only reset preempts.
// RULE9 - Hard fault raised on error, fixed priority -1.
// RULE10 - Supervisor call number 11, configurable priority, vector 0x2C.
// RULE11 - Software can make pendable service request pending.
// RULE12 - System tick pending on timer zero or by software.
// RULE13 - Interrupt requests accepted any time, asynchronously.
// RULE14 - Numbers 1,2,3 with vectors 0x4,0x8,0xC; 4-10 reserved.
// RULE15 - Configurable priorities 0-3, lower is higher; fixed always outrank.
// RULE16 - Equal priority pending ties go to lowest number.
// RULE17 - Equal priority never preempts; the newcomer stays pending.
// RULE18 - Vector table at zero; interrupts from 0x40, four bytes each.
// RULE19 - Interrupt requests synchronised before updating pending state.
`timescale 1ns/1ps
`include "exc_defs.vh"
module exc_state (
  input  wire        clk,
  input  wire        rst,
  // Peripheral and software requests
  input  wire [31:0] irq_req,
  input  wire [31:0] irq_set_pend,
  input  wire [31:0] irq_clr_pend,
  input  wire [63:0] irq_pri,
  input  wire [1:0]  sup_pri,
  input  wire [1:0]  pendreq_pri,
  input  wire [1:0]  tick_pri,
  input  wire        fault_evt,
  input  wire        sup_exec,
  input  wire        pendreq_set,
  input  wire        pendreq_clr,
  input  wire        tick_zero,
  input  wire        tick_set,
  input  wire        tick_clr,
  // Pipeline handshake
  input  wire        entry_ack,
  input  wire        exc_return,
  // Exception state seen by the core
  output wire        take_req,
  output wire [5:0]  take_num,
  output wire [31:0] take_vec,
  output wire [5:0]  cur_num,
  output wire        thread_mode,
  output wire        core_halt,
  output wire [47:0] pend_state,
  output wire [47:0] act_state
);
  localparam ST_RESET = 3'b001;
  localparam ST_RUN   = 3'b010;
  localparam ST_ENTRY = 3'b100;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [5:0]  stack_r [0:47];
  reg  [5:0]  sp_r;
  reg  [5:0]  sp_nxt;
  reg  [2:0]  cur_pri_r;
  reg  [2:0]  cur_pri_nxt;
  reg  [5:0]  cur_num_r;
  reg  [5:0]  cur_num_nxt;
  reg  [5:0]  take_num_r;
  reg  [5:0]  take_num_nxt;
  reg  [31:0] take_vec_r;
  reg  [31:0] take_vec_nxt;
  reg         thread_r;
  reg         thread_nxt;
  reg         halt_r;
  reg  [47:0] pend_r;
  reg  [47:0] pend_nxt;
  reg  [47:0] act_r;
  reg  [47:0] act_nxt;
  reg  [2:0]  best_pri;
  reg  [5:0]  best_num;
  reg  [47:0] set_v;
  reg  [47:0] clr_v;
  reg         do_take;
  reg         do_entry;
  reg         do_return;
  wire [31:0] irq_rise;
  wire [5:0]  ret_num;
  integer     i;

  // RULE3 nest on higher
  // RULE17 equal does not preempt
  function preempts;
    input [2:0] cand;
    input [2:0] run;
    begin
      preempts = (cand < run);
    end
  endfunction

  // One-hot select of an exception slot
  function [47:0] slot;
    input [5:0] n;
    begin
      slot = 48'h0000_0000_0001 << n;
    end
  endfunction

  // Priority is widened to 3 bits so fixed levels sort below all configurable ones
  function [2:0] src_pri;
    input [5:0] n;
    begin
      case (n)
        // RULE7 reset highest
        `EXC_NUM_RESET: src_pri = `PRI_RESET;
        // RULE8 fixed nmi
        `EXC_NUM_NMI:   src_pri = `PRI_NMI;
        // RULE9 fixed fault
        `EXC_NUM_HARD:  src_pri = `PRI_HARD;
        // RULE15 configurable range
        `EXC_NUM_SUP:     src_pri = `PRI_CFG_OFS + {1'b0, sup_pri};
        `EXC_NUM_PENDREQ: src_pri = `PRI_CFG_OFS + {1'b0, pendreq_pri};
        `EXC_NUM_TICK:  src_pri = `PRI_CFG_OFS + {1'b0, tick_pri};
        default: begin
          if (n >= `EXC_NUM_IRQ0)
            src_pri = `PRI_CFG_OFS + {1'b0, irq_pri[(n - `EXC_NUM_IRQ0) * 2 +: 2]};
          else
            src_pri = `PRI_IDLE;
        end
      endcase
    end
  endfunction

  function [31:0] vec_addr;
    input [5:0] n;
    begin
      // RULE14 fixed vectors
      // RULE18 table at zero
      vec_addr = `VEC_BASE + {24'h00_0000, n, 2'b00};
    end
  endfunction

  // RULE19 synchronise requests
  irq_sync u_sync (
    .clk       (clk),
    .rst       (rst),
    .irq_async (irq_req),
    .irq_rise  (irq_rise)
  );

  // Outputs straight from flip-flops
  assign take_num    = take_num_r;
  assign take_vec    = take_vec_r;
  assign cur_num     = cur_num_r;
  assign thread_mode = thread_r;
  assign core_halt   = halt_r;
  assign pend_state  = pend_r;
  assign act_state   = act_r;
  // Only read while sp_r is non-zero
  assign ret_num     = stack_r[sp_r - 6'h01];

  always @* begin
    set_v = 48'h0000_0000_0000;
    clr_v = 48'h0000_0000_0000;
    // RULE2 peripheral or software
    // RULE13 async irq accepted
    set_v[47:16] = irq_rise | irq_set_pend;
    clr_v[47:16] = irq_clr_pend;
    // RULE9 fault raises
    set_v[3] = fault_evt;
    // RULE10 svc on instruction
    set_v[11] = sup_exec;
    // RULE11 software pendable
    set_v[14] = pendreq_set;
    clr_v[14] = pendreq_clr;
    // RULE12 tick zero or software
    set_v[15] = tick_zero | tick_set;
    clr_v[15] = tick_clr;
    // Entry consumes the pending bit of the taken source
    if (do_entry)
      clr_v = clr_v | slot(take_num_r);
    // RULE5 nmi never pends
    set_v[2] = 1'b0;
    // RULE4 set wins over clear
    pend_nxt = (pend_r & ~clr_v) | set_v;
  end

  always @* begin
    do_entry  = (state_r == ST_ENTRY) && entry_ack;
    // Return in thread mode has nothing to pop
    do_return = (state_r == ST_RUN) && exc_return && (sp_r != 6'h00);
    do_take   = (state_r == ST_RUN) && (best_num != `EXC_NUM_NONE) && preempts(best_pri, cur_pri_r);
  end

  always @* begin
    best_pri = `PRI_IDLE;
    best_num = `EXC_NUM_NONE;
    // RULE16 lowest number wins ties
    for (i = 47; i >= 1; i = i - 1) begin
      if (pend_r[i] && src_pri(i[5:0]) <= best_pri) begin
        best_pri = src_pri(i[5:0]);
        best_num = i[5:0];
      end
    end
  end

  assign take_req = (state_r == ST_ENTRY);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RESET: state_nxt = ST_RUN;
      ST_RUN: begin
        if (do_take)
          state_nxt = ST_ENTRY;
      end
      ST_ENTRY: begin
        if (entry_ack)
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RESET;
    endcase
  end

  always @* begin
    sp_nxt       = sp_r;
    cur_num_nxt  = cur_num_r;
    cur_pri_nxt  = cur_pri_r;
    thread_nxt   = thread_r;
    act_nxt      = act_r;
    take_num_nxt = take_num_r;
    take_vec_nxt = take_vec_r;
    if (do_take) begin
      take_num_nxt = best_num;
      take_vec_nxt = vec_addr(best_num);
    end
    if (do_entry) begin
      // RULE1 active beside pending
      sp_nxt      = sp_r + 6'h01;
      act_nxt     = act_r | slot(take_num_r);
      cur_num_nxt = take_num_r;
      cur_pri_nxt = src_pri(take_num_r);
      thread_nxt  = 1'b0;
    end else if (do_return) begin
      // Return pops to the interrupted handler or thread
      act_nxt     = act_r & ~slot(cur_num_r);
      sp_nxt      = sp_r - 6'h01;
      cur_num_nxt = ret_num;
      cur_pri_nxt = src_pri(ret_num);
      thread_nxt  = (sp_r == 6'h01);
    end
  end

  // RULE6 reset halts at once
  always @(posedge clk) begin
    if (rst) begin
      state_r <= ST_RESET;
      halt_r  <= 1'b1;
    end else begin
      state_r <= state_nxt;
      halt_r  <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      pend_r <= 48'h0000_0000_0000;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      sp_r      <= 6'h00;
      cur_pri_r <= `PRI_IDLE;
      cur_num_r <= `EXC_NUM_NONE;
      act_r     <= 48'h0000_0000_0000;
      thread_r  <= 1'b1;
    end else begin
      sp_r      <= sp_nxt;
      cur_pri_r <= cur_pri_nxt;
      cur_num_r <= cur_num_nxt;
      act_r     <= act_nxt;
      thread_r  <= thread_nxt;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      // RULE7 restart at reset vector
      take_num_r <= `EXC_NUM_RESET;
      take_vec_r <= `VEC_RESET;
    end else begin
      take_num_r <= take_num_nxt;
      take_vec_r <= take_vec_nxt;
    end
  end

  // Frame store needs no reset; sp_r guards every read
  always @(posedge clk) begin
    if (!rst && do_entry)
      stack_r[sp_r] <= cur_num_r;
  end
endmodule // exc_state

// *** test/pipe_model.sv ***
`timescale 1ns/1ps
module pipe_model (
  input  wire       clk,
  input  wire       take_req,
  input  wire [1:0] lat,
  output reg        entry_ack
);
  reg [1:0] cnt_r;
  initial entry_ack = 1'b0;
  initial cnt_r = 2'h0;
  // Ack only while a take stands; lat stalls it
  always @(negedge clk) begin
    entry_ack <= 1'b0;
    cnt_r <= 2'h0;
    if (take_req && !entry_ack && cnt_r != lat)
      cnt_r <= cnt_r + 2'h1;
    else if (take_req && !entry_ack)
      entry_ack <= 1'b1;
  end
endmodule // pipe_model

// *** test/exc_state_checker.sv ***
`timescale 1ns/1ps
module exc_state_checker (
  input wire        clk,
  input wire        rst,
  input wire        take_req,
  input wire [5:0]  take_num,
  input wire [31:0] take_vec,
  input wire [5:0]  cur_num,
  input wire [47:0] pend_state,
  input wire [47:0] act_state,
  input wire        entry_ack,
  input wire        fault_evt,
  input wire        sup_exec,
  input wire        pendreq_set,
  input wire        tick_zero
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_nmi; !(pend_state[2] | act_state[2]); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi");
  property p_resv; pend_state[10:4] == 7'h00; endproperty
  a_resv: assert property (p_resv) else $error("reserved");
  property p_hard; fault_evt |=> pend_state[3]; endproperty
  a_hard: assert property (p_hard) else $error("fault");
  property p_sup; sup_exec |=> pend_state[11]; endproperty
  a_sup: assert property (p_sup) else $error("call");
  property p_psv; pendreq_set |=> pend_state[14]; endproperty
  a_psv: assert property (p_psv) else $error("service");
  property p_tick; tick_zero |=> pend_state[15]; endproperty
  a_tick: assert property (p_tick) else $error("tick");
  property p_vec; take_req |-> take_vec == {24'h00_0000, take_num, 2'b00}; endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_nest; entry_ack && cur_num != 6'h00 |=> act_state[$past(cur_num)]; endproperty
  a_nest: assert property (p_nest) else $error("nest");
endmodule // exc_state_checker

bind exc_state exc_state_checker chk (.clk(clk), .rst(rst), .take_req(take_req), .take_num(take_num),
  .take_vec(take_vec), .cur_num(cur_num), .pend_state(pend_state), .act_state(act_state),
  .entry_ack(entry_ack), .fault_evt(fault_evt), .sup_exec(sup_exec), .pendreq_set(pendreq_set),
  .tick_zero(tick_zero));

// *** test/exc_state_tb.sv ***
`timescale 1ns/1ps
module exc_state_tb;
  reg         clk;
  reg         rst;
  reg  [31:0] irq_req;
  reg  [31:0] set_p;
  reg  [31:0] clr_p;
  reg  [63:0] pri;
  reg  [6:0]  ev;
  reg         ret_r;
  reg  [1:0]  lat;
  wire        take_req;
  wire        entry_ack;
  wire [5:0]  take_num;
  wire [5:0]  cur_num;
  wire [31:0] take_vec;
  wire        thread_mode;
  wire        core_halt;
  wire [47:0] pend_state;
  wire [47:0] act_state;
  integer     mismatches;
  integer     comparisons;
  integer     i;
  integer     n;
  exc_state dut (.clk(clk), .rst(rst), .irq_req(irq_req), .irq_set_pend(set_p), .irq_clr_pend(clr_p),
    .irq_pri(pri), .sup_pri(pri[1:0]), .pendreq_pri(pri[3:2]), .tick_pri(pri[5:4]), .fault_evt(ev[0]),
    .sup_exec(ev[1]), .pendreq_set(ev[2]), .tick_zero(ev[3]), .tick_set(ev[4]), .pendreq_clr(ev[5]),
    .tick_clr(ev[6]), .entry_ack(entry_ack), .exc_return(ret_r), .take_req(take_req), .take_num(take_num),
    .take_vec(take_vec), .cur_num(cur_num), .thread_mode(thread_mode), .core_halt(core_halt),
    .pend_state(pend_state), .act_state(act_state));
  pipe_model pipe (.clk(clk), .take_req(take_req), .lat(lat), .entry_ack(entry_ack));
  always #50 clk = ~clk;
  function [5:0] sysn(input integer j);
    sysn = (j == 0) ? 6'h03 : (j == 1) ? 6'h0B : (j == 2) ? 6'h0E : 6'h0F;
  endfunction
  task chk(input [47:0] seen, input [47:0] exp, input string what);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task step;
    begin
      @(negedge clk);
      #1;
    end
  endtask
  task pulse(input [6:0] m, input [31:0] s);
    begin
      ev = m;
      set_p = s;
      step;
      ev = 7'h00;
      set_p = 32'h0000_0000;
    end
  endtask
  task ret;
    begin
      ret_r = 1'b1;
      step;
      ret_r = 1'b0;
      step;
    end
  endtask
  // Waits for the pipeline ack, bounded
  task go(input [5:0] num);
    integer k;
    begin
      k = 0;
      while (entry_ack !== 1'b1 && k < 40) begin
        step;
        k = k + 1;
      end
      if (entry_ack !== 1'b1) begin
        mismatches = mismatches + 1;
        report_and_stop;
      end
      chk(take_num, num, "take_num");
      chk(take_vec, {num, 2'b00}, "take_vec");
      step;
      chk(cur_num, num, "cur_num");
      chk(act_state[num], 1'b1, "active");
    end
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    irq_req = 32'h0000_0000;
    set_p = 32'h0000_0000;
    clr_p = 32'h0000_0000;
    pri = 64'h0000_0000_0000_0000;
    ev = 7'h00;
    ret_r = 1'b0;
    lat = 2'h0;
    mismatches = 0;
    comparisons = 0;
    n = $urandom(32'ha726);
    repeat (8) step;
    chk(core_halt, 1'b1, "halt");
    chk(take_vec, 32'h0000_0004, "reset_vec");
    rst = 1'b0;
    repeat (2) step;
    chk({thread_mode, core_halt, act_state}, {2'b10, 48'h0000_0000_0000}, "restart");
    for (i = 0; i < 5; i = i + 1) begin
      lat = i[1:0];
      pulse(7'h01 << i, 32'h0000_0000);
      go(sysn(i));
      ret;
      chk(thread_mode, 1'b1, "thread");
    end
    $display("test system done");
    for (i = 0; i < 8; i = i + 1) begin
      n = $urandom % 32;
      pri = {$urandom, $urandom};
      lat = $urandom % 4;
      // Peripheral level, async to the clock
      irq_req[n] = 1'b1;
      go(6'h10 + n[5:0]);
      ret;
      irq_req[n] = 1'b0;
      repeat (3) step;
    end
    $display("test irq done");
    pri = 64'h0000_0000_0000_0000;
    pulse(7'h00, 32'h0000_0006);
    go(6'h11);
    chk(pend_state[18], 1'b1, "eq_pend");
    pulse(7'h00, 32'h0000_0002);
    step;
    chk(pend_state[17] & act_state[17], 1'b1, "act_pend");
    pulse(7'h01, 32'h0000_0000);
    go(6'h03);
    chk(act_state[17], 1'b1, "nested");
    pulse(7'h04, 32'h0000_0020);
    chk({pend_state[21], pend_state[14]}, 2'b11, "held");
    clr_p = 32'h0000_0020;
    pulse(7'h20, 32'h0000_0000);
    clr_p = 32'h0000_0000;
    chk({pend_state[21], pend_state[14]}, 2'b00, "cleared");
    ret;
    chk(cur_num, 6'h11, "resume");
    ret;
    go(6'h11);
    ret;
    go(6'h12);
    ret;
    $display("test nesting done");
    // Reset lands while a fault is pending, before it is taken
    pulse(7'h01, 32'h0000_0000);
    rst = 1'b1;
    step;
    chk({core_halt, thread_mode, pend_state[3]}, 3'b110, "mid_reset");
    rst = 1'b0;
    repeat (2) step;
    chk({core_halt, thread_mode, cur_num}, {2'b01, 6'h00}, "mid_restart");
    $display("test reset done");
    report_and_stop;
  end
endmodule // exc_state_tb
